/* File: core/tlb_index_random_entry_regs.sv */
// Probe index, victim counter and page mapping registers of the TLB
// How it works
// - Probe index register's low five bits pick the entry for read and indexed write; a probe hit loads them.
// - Index field is five bits, enough for all thirty-two entries.
// - Top bit of probe index is set when the last probe missed.
// - Bits 30:5 of probe index read zero; software writes zeros.
// - Read-only victim counter gives the entry for random writes.
// - Victim counter upper bound is entry count minus one.
// - Victim counter counts down most clocks, wrapping from lower to upper bound.
// - Shift register randomly holds the count to avoid live lock.
// - Victim counter bits 31:5 read zero; writes ignored.
// - Enabled read inhibit makes data reads fault invalid; else bit is zero.
// - Enabled fetch inhibit makes fetches fault invalid; else bit is zero.
// - Frame number is 20 bits; bits 29:26 are zeros.
// - Small pages map frame to address 29:10, else from bit 12 up.
// - Three-bit coherency field per page, read-write.
// - Store to a clean page faults modified; dirty pages allow stores.
// - Any access to an invalid page faults invalid.
// - Entry global is AND of both globals; read returns it in both.
// - Coherency codes four to six act as three, seven as two.
`timescale 1ns/1ps
module tlb_index_random_entry_regs (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   // Coprocessor register port
   input  wire logic        cop_wr_i,
   input  wire logic        cop_rd_i,
   input  wire logic [1:0]  cop_sel_i,
   input  wire logic [31:0] cop_wdata_i,
   output logic      [31:0] cop_rdata_o,
   // Configuration levels
   input  wire logic        small_page_support_i,
   input  wire logic        small_page_enable_i,
   input  wire logic        read_inhibit_enable_i,
   input  wire logic        fetch_inhibit_enable_i,
   input  wire logic [4:0]  locked_count_i,
   input  wire logic        locked_wr_i,
   // TLB operations
   input  wire logic        probe_op_i,
   input  wire logic        probe_hit_i,
   input  wire logic [4:0]  probe_idx_i,
   input  wire logic        entry_read_op_i,
   input  wire logic [31:0] tlb_rd_even_i,
   input  wire logic [31:0] tlb_rd_odd_i,
   input  wire logic        tlb_rd_global_i,
   input  wire logic        indexed_write_op_i,
   input  wire logic        random_write_op_i,
   output logic             tlb_wr_o,
   output logic      [4:0]  tlb_wr_idx_o,
   output logic      [31:0] tlb_wr_even_o,
   output logic      [31:0] tlb_wr_odd_o,
   output logic             tlb_wr_global_o,
   output logic      [4:0]  read_idx_o,
   // Access check on the matched page
   input  wire logic        acc_req_i,
   input  wire logic [1:0]  acc_kind_i,
   input  wire logic [31:0] acc_page_i,
   input  wire logic [11:0] acc_offset_i,
   output logic             acc_done_o,
   output logic             tlb_invalid_o,
   output logic             tlb_modified_o,
   output logic      [31:0] phys_addr_o,
   output logic      [2:0]  cache_attr_o
);

   typedef struct packed {
      logic        probe_fail;
      logic [4:0]  index;
      logic [4:0]  victim;
      logic [31:0] even;
      logic [31:0] odd;
      logic [31:0] rdata;
      logic        wr;
      logic [4:0]  wr_idx;
      logic [31:0] wr_even;
      logic [31:0] wr_odd;
      logic        wr_global;
      logic        done;
      logic        inv;
      logic        modi;
      logic [31:0] pa;
      logic [2:0]  attr;
   } regs_state_t;

   regs_state_t state;
   regs_state_t next_state;
   logic        hold;
   logic        is_load;
   logic        is_fetch;
   logic        is_store;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Clears inhibit bits that are not enabled and the unused frame bits
   function automatic logic [31:0] page_mask(input logic [31:0] d,
                                             input logic        read_inhibit_enable,
                                             input logic        fetch_inhibit_enable);
      logic [31:0] m;
      m = d;
      m[tlb_regs_pkg::READ_INH_BIT]  = d[tlb_regs_pkg::READ_INH_BIT] & read_inhibit_enable;
      m[tlb_regs_pkg::FETCH_INH_BIT] = d[tlb_regs_pkg::FETCH_INH_BIT] & fetch_inhibit_enable;
      m[tlb_regs_pkg::ZERO_MSB:tlb_regs_pkg::ZERO_LSB] = 4'h0;
      return m;
   endfunction

   // Folds unused coherency codes onto the four that the core uses
   function automatic logic [2:0] coh_fold(input logic [2:0] c);
      logic [2:0] r;
      r = c;
      if (c == tlb_regs_pkg::COH_MAP_UC) begin
         r = tlb_regs_pkg::COH_UNCACHED;
      end else if (c > tlb_regs_pkg::COH_WB_ALLOC) begin
         r = tlb_regs_pkg::COH_WB_ALLOC;
      end
      return r;
   endfunction

   victim_lfsr u_lfsr (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .hold_o (hold)
   );

   assign is_fetch = acc_kind_i == tlb_regs_pkg::ACC_FETCH;
   assign is_load  = acc_kind_i == tlb_regs_pkg::ACC_LOAD;
   assign is_store = acc_kind_i == tlb_regs_pkg::ACC_STORE;

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_state      = state;
      next_state.wr   = 1'b0;
      next_state.done = 1'b0;

      // Victim counter; an out-of-range value after a locked-count change
      // is caught here too, so the counter is back inside its window one clock later
      if (locked_wr_i) begin
         next_state.victim = tlb_regs_pkg::VICTIM_TOP;
      end else if (state.victim < locked_count_i) begin
         next_state.victim = tlb_regs_pkg::VICTIM_TOP;
      end else if (hold) begin
         next_state.victim = state.victim;
      end else if (state.victim == locked_count_i) begin
         next_state.victim = tlb_regs_pkg::VICTIM_TOP;
      end else begin
         next_state.victim = state.victim - 5'h01;
      end

      // Software writes; the victim counter ignores them
      if (cop_wr_i) begin
         if (cop_sel_i == tlb_regs_pkg::SEL_PROBE_INDEX) begin
            next_state.index = cop_wdata_i[4:0];
         end else if (cop_sel_i == tlb_regs_pkg::SEL_EVEN_PAGE) begin
            next_state.even = page_mask(cop_wdata_i, read_inhibit_enable_i,
                                        fetch_inhibit_enable_i);
         end else if (cop_sel_i == tlb_regs_pkg::SEL_ODD_PAGE) begin
            next_state.odd = page_mask(cop_wdata_i, read_inhibit_enable_i,
                                       fetch_inhibit_enable_i);
         end
      end

      // Hardware updates win over a software write in the same clock
      if (probe_op_i) begin
         next_state.probe_fail = !probe_hit_i;
         if (probe_hit_i) begin
            next_state.index = probe_idx_i;
         end
      end

      if (entry_read_op_i) begin
         next_state.even = page_mask(tlb_rd_even_i, read_inhibit_enable_i,
                                     fetch_inhibit_enable_i);
         next_state.odd  = page_mask(tlb_rd_odd_i, read_inhibit_enable_i,
                                     fetch_inhibit_enable_i);
         next_state.even[tlb_regs_pkg::GLOBAL_BIT] = tlb_rd_global_i;
         next_state.odd[tlb_regs_pkg::GLOBAL_BIT]  = tlb_rd_global_i;
      end

      if (indexed_write_op_i || random_write_op_i) begin
         next_state.wr        = 1'b1;
         next_state.wr_idx    = random_write_op_i ? state.victim : state.index;
         next_state.wr_even   = state.even;
         next_state.wr_odd    = state.odd;
         next_state.wr_global = state.even[tlb_regs_pkg::GLOBAL_BIT] &
                                state.odd[tlb_regs_pkg::GLOBAL_BIT];
      end

      // Register reads
      if (cop_rd_i) begin
         if (cop_sel_i == tlb_regs_pkg::SEL_PROBE_INDEX) begin
            next_state.rdata = {state.probe_fail, 26'h0000000, state.index};
         end else if (cop_sel_i == tlb_regs_pkg::SEL_VICTIM) begin
            next_state.rdata = {27'h0000000, state.victim};
         end else if (cop_sel_i == tlb_regs_pkg::SEL_EVEN_PAGE) begin
            next_state.rdata = state.even;
         end else begin
            next_state.rdata = state.odd;
         end
      end

      // Access check on the matched page
      if (acc_req_i) begin
         next_state.done = 1'b1;
         next_state.inv  = !acc_page_i[tlb_regs_pkg::VALID_BIT]
            || (is_load && read_inhibit_enable_i
                && acc_page_i[tlb_regs_pkg::READ_INH_BIT])
            || (is_fetch && fetch_inhibit_enable_i
                && acc_page_i[tlb_regs_pkg::FETCH_INH_BIT]);
         next_state.modi = is_store && acc_page_i[tlb_regs_pkg::VALID_BIT]
                           && !acc_page_i[tlb_regs_pkg::DIRTY_BIT];
         if (small_page_support_i && small_page_enable_i) begin
            next_state.pa = {2'h0,
               acc_page_i[tlb_regs_pkg::FRAME_MSB:tlb_regs_pkg::FRAME_LSB],
               acc_offset_i[9:0]};
         end else begin
            next_state.pa = {
               acc_page_i[tlb_regs_pkg::FRAME_MSB:tlb_regs_pkg::FRAME_LSB],
               acc_offset_i};
         end
         next_state.attr = coh_fold(
            acc_page_i[tlb_regs_pkg::COH_MSB:tlb_regs_pkg::COH_LSB]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         state            <= '0;
         state.index      <= tlb_regs_pkg::INDEX_RST;
         state.victim     <= tlb_regs_pkg::VICTIM_TOP;
         state.even       <= tlb_regs_pkg::PAGE_RST;
         state.odd        <= tlb_regs_pkg::PAGE_RST;
      end else begin
         state <= next_state;
      end
   end

   assign cop_rdata_o     = state.rdata;
   assign tlb_wr_o        = state.wr;
   assign tlb_wr_idx_o    = state.wr_idx;
   assign tlb_wr_even_o   = state.wr_even;
   assign tlb_wr_odd_o    = state.wr_odd;
   assign tlb_wr_global_o = state.wr_global;
   assign read_idx_o      = state.index;
   assign acc_done_o      = state.done;
   assign tlb_invalid_o   = state.inv;
   assign tlb_modified_o  = state.modi;
   assign phys_addr_o     = state.pa;
   assign cache_attr_o    = state.attr;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_victim_window;
      @(posedge clk_i) disable iff (!nrst_i)
      $rose(nrst_i) or (!$past(locked_wr_i) && $past(state.victim) >= locked_count_i)
      |-> state.victim >= locked_count_i && state.victim <= tlb_regs_pkg::VICTIM_TOP;
   endproperty
   a_victim_window: assert property (p_victim_window)
      else $error("victim counter outside its window");

   property p_victim_load;
      @(posedge clk_i) disable iff (!nrst_i)
      locked_wr_i |=> state.victim == tlb_regs_pkg::VICTIM_TOP;
   endproperty
   a_victim_load: assert property (p_victim_load)
      else $error("victim counter not loaded on locked write");

   property p_victim_step;
      @(posedge clk_i) disable iff (!nrst_i)
      !locked_wr_i && !hold && state.victim > locked_count_i
      |=> state.victim == $past(state.victim) - 5'h01;
   endproperty
   a_victim_step: assert property (p_victim_step)
      else $error("victim counter did not decrement");

   property p_victim_wrap;
      @(posedge clk_i) disable iff (!nrst_i)
      !locked_wr_i && !hold && state.victim == locked_count_i
      |=> state.victim == tlb_regs_pkg::VICTIM_TOP;
   endproperty
   a_victim_wrap: assert property (p_victim_wrap)
      else $error("victim counter did not wrap");

   property p_victim_hold;
      @(posedge clk_i) disable iff (!nrst_i)
      !locked_wr_i && hold && state.victim >= locked_count_i |=> $stable(state.victim);
   endproperty
   a_victim_hold: assert property (p_victim_hold)
      else $error("victim counter moved while held");

   property p_probe_miss;
      @(posedge clk_i) disable iff (!nrst_i)
      probe_op_i && !probe_hit_i ##1 cop_rd_i && cop_sel_i == tlb_regs_pkg::SEL_PROBE_INDEX
      |=> cop_rdata_o[31] && cop_rdata_o[30:5] == 26'h0000000;
   endproperty
   a_probe_miss: assert property (p_probe_miss)
      else $error("probe miss not flagged");

   property p_victim_read;
      @(posedge clk_i) disable iff (!nrst_i)
      cop_rd_i && cop_sel_i == tlb_regs_pkg::SEL_VICTIM
      |=> cop_rdata_o == {27'h0000000, $past(state.victim)};
   endproperty
   a_victim_read: assert property (p_victim_read)
      else $error("victim read value wrong");

   property p_random_write;
      @(posedge clk_i) disable iff (!nrst_i)
      random_write_op_i |=> tlb_wr_o && tlb_wr_idx_o == $past(state.victim);
   endproperty
   a_random_write: assert property (p_random_write)
      else $error("random write used wrong entry");

   property p_global_and;
      @(posedge clk_i) disable iff (!nrst_i)
      indexed_write_op_i |=> tlb_wr_global_o == ($past(state.even[0]) & $past(state.odd[0]));
   endproperty
   a_global_and: assert property (p_global_and)
      else $error("written global is not the AND");

   property p_store_clean;
      @(posedge clk_i) disable iff (!nrst_i)
      acc_req_i && is_store && acc_page_i[1] && !acc_page_i[2] |=> tlb_modified_o && acc_done_o;
   endproperty
   a_store_clean: assert property (p_store_clean)
      else $error("store to clean page not faulted");

   property p_invalid_page;
      @(posedge clk_i) disable iff (!nrst_i)
      acc_req_i && !acc_page_i[1] |=> tlb_invalid_o && !tlb_modified_o;
   endproperty
   a_invalid_page: assert property (p_invalid_page)
      else $error("invalid page access not faulted");

endmodule // tlb_index_random_entry_regs

/* File: core/tlb_regs_pkg.sv */
// Constants shared by the translation register slice
package tlb_regs_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Sizes
   localparam int          TLB_ENTRIES = 32;
   localparam int          IDX_W       = 5;
   localparam logic [4:0]  VICTIM_TOP  = 5'h1f;
   localparam int          LFSR_W      = 16;
   localparam logic [15:0] LFSR_SEED   = 16'hace1;
   localparam logic [15:0] LFSR_TAPS   = 16'hb400;

   ////////////////////////////////////////////////////////////////////////
   // Register selects
   localparam logic [1:0] SEL_PROBE_INDEX = 2'h0;
   localparam logic [1:0] SEL_VICTIM      = 2'h1;
   localparam logic [1:0] SEL_EVEN_PAGE   = 2'h2;
   localparam logic [1:0] SEL_ODD_PAGE    = 2'h3;

   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int PROBE_FAIL_BIT = 31;
   localparam int READ_INH_BIT   = 31;
   localparam int FETCH_INH_BIT  = 30;
   localparam int ZERO_MSB       = 29;
   localparam int ZERO_LSB       = 26;
   localparam int FRAME_MSB      = 25;
   localparam int FRAME_LSB      = 6;
   localparam int COH_MSB        = 5;
   localparam int COH_LSB        = 3;
   localparam int DIRTY_BIT      = 2;
   localparam int VALID_BIT      = 1;
   localparam int GLOBAL_BIT     = 0;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [4:0]  INDEX_RST = 5'h00;
   localparam logic [31:0] PAGE_RST  = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////
   // Coherency codes
   localparam logic [2:0] COH_WT_NOALLOC = 3'h0;
   localparam logic [2:0] COH_WT_ALLOC   = 3'h1;
   localparam logic [2:0] COH_UNCACHED   = 3'h2;
   localparam logic [2:0] COH_WB_ALLOC   = 3'h3;
   localparam logic [2:0] COH_MAP_UC     = 3'h7;

   typedef enum logic [1:0] {
      ACC_FETCH = 2'h0,
      ACC_LOAD  = 2'h1,
      ACC_STORE = 2'h3
   } acc_kind_t;

endpackage

/* File: core/victim_lfsr.sv */
// Pseudo-random hold source for the victim counter
`timescale 1ns/1ps
module victim_lfsr (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic nrst_i,
   // Hold request
   output logic      hold_o
);

   typedef struct packed {
      logic [15:0] sr;
   } lfsr_state_t;

   lfsr_state_t state;
   lfsr_state_t next_state;

   ////////////////////////////////////////////////////////////////////////
   // Galois shift; holds about one clock in four so the count still moves
   always_comb begin
      next_state = state;
      if (state.sr[0]) begin
         next_state.sr = (state.sr >> 1) ^ tlb_regs_pkg::LFSR_TAPS;
      end else begin
         next_state.sr = state.sr >> 1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         state.sr <= tlb_regs_pkg::LFSR_SEED;
      end else begin
         state <= next_state;
      end
   end

   assign hold_o = state.sr[0] & state.sr[1];

endmodule // victim_lfsr

/* File: verif/pipe_model.sv */
// Pipeline model that issues register moves into the translation register slice
`timescale 1ns/1ps
module pipe_model (
   // Clock
   input  wire logic        clk_i,
   // Register port towards the slice
   output logic             cop_wr_o,
   output logic             cop_rd_o,
   output logic      [1:0]  cop_sel_o,
   output logic      [31:0] cop_wdata_o,
   input  wire logic [31:0] cop_rdata_i
);
   initial begin
      cop_wr_o    = 1'h0;
      cop_rd_o    = 1'h0;
      cop_sel_o   = 2'h0;
      cop_wdata_o = 32'h0000_0000;
   end

   ////////////////////////////////////////////////////////////////////////
   // Legal writes clear reserved bits; raw writes exist only to probe refusals
   task automatic wr_reg(input logic [1:0] sel, input logic [31:0] d, input bit raw);
      logic [31:0] w;
      w = d;
      if (!raw && sel == tlb_regs_pkg::SEL_PROBE_INDEX) begin
         w = {27'h0, d[4:0]};
      end
      if (!raw && sel[1]) begin
         w[29:26] = 4'h0;
      end
      cop_sel_o   = sel;
      cop_wdata_o = w;
      cop_wr_o    = 1'h1;
      @(posedge clk_i);
      #1;
      cop_wr_o = 1'h0;
      // Idle cycle so the strobe is never lowered and raised in one step
      @(posedge clk_i);
      #1;
   endtask

   // Page words read back are trusted only when no translation fault came between
   task automatic rd_reg(input logic [1:0] sel, output logic [31:0] d);
      cop_sel_o = sel;
      cop_rd_o  = 1'h1;
      @(posedge clk_i);
      #1;
      cop_rd_o = 1'h0;
      d        = cop_rdata_i;
      @(posedge clk_i);
      #1;
   endtask
endmodule // pipe_model

/* File: verif/tlb_index_random_entry_regs_tb_top.sv */
// Self-checking bench for the translation register slice
`timescale 1ns/1ps
module tlb_index_random_entry_regs_tb_top;
   logic        clk = 1'h0, nrst = 1'h0;
   logic        cop_wr, cop_rd;
   logic [1:0]  cop_sel;
   logic [31:0] cop_wdata, cop_rdata, v;
   logic        sp_sup = 1'h0, sp_en = 1'h0, ri_en = 1'h0, xi_en = 1'h0;
   logic [4:0]  locked = 5'h00, probe_idx = 5'h00, wr_idx, rd_idx;
   logic        locked_wr = 1'h0, probe_op = 1'h0, probe_hit = 1'h0, ent_rd = 1'h0;
   logic [31:0] rd_even = 32'h0, rd_odd = 32'h0, wr_even, wr_odd, acc_page = 32'h0, pa;
   logic        rd_glob = 1'h0, iw_op = 1'h0, rw_op = 1'h0, tlb_wr, wr_glob;
   logic        acc_req = 1'h0, acc_done, inval, modif;
   logic [1:0]  acc_kind = 2'h0;
   logic [11:0] acc_off = 12'h000;
   logic [2:0]  attr;
   logic [2:0]  amap [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h3, 3'h3, 3'h3, 3'h2};
   int          n_fail = 0, cmp_count = 0;

   always #2 clk = ~clk;

   pipe_model pipe (.clk_i(clk), .cop_wr_o(cop_wr), .cop_rd_o(cop_rd), .cop_sel_o(cop_sel),
                    .cop_wdata_o(cop_wdata), .cop_rdata_i(cop_rdata));

   tlb_index_random_entry_regs DUT (
      .clk_i(clk), .nrst_i(nrst), .cop_wr_i(cop_wr), .cop_rd_i(cop_rd), .cop_sel_i(cop_sel),
      .cop_wdata_i(cop_wdata), .cop_rdata_o(cop_rdata), .small_page_support_i(sp_sup),
      .small_page_enable_i(sp_en), .read_inhibit_enable_i(ri_en),
      .fetch_inhibit_enable_i(xi_en), .locked_count_i(locked), .locked_wr_i(locked_wr),
      .probe_op_i(probe_op), .probe_hit_i(probe_hit), .probe_idx_i(probe_idx),
      .entry_read_op_i(ent_rd), .tlb_rd_even_i(rd_even), .tlb_rd_odd_i(rd_odd),
      .tlb_rd_global_i(rd_glob), .indexed_write_op_i(iw_op), .random_write_op_i(rw_op),
      .tlb_wr_o(tlb_wr), .tlb_wr_idx_o(wr_idx), .tlb_wr_even_o(wr_even),
      .tlb_wr_odd_o(wr_odd), .tlb_wr_global_o(wr_glob), .read_idx_o(rd_idx),
      .acc_req_i(acc_req), .acc_kind_i(acc_kind), .acc_page_i(acc_page),
      .acc_offset_i(acc_off), .acc_done_o(acc_done), .tlb_invalid_o(inval),
      .tlb_modified_o(modif), .phys_addr_o(pa), .cache_attr_o(attr));

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic tick();
      @(posedge clk);
      #1;
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Victim is read first, before it has had a chance to move
   task automatic t_reset();
      pipe.rd_reg(tlb_regs_pkg::SEL_VICTIM, v);
      chk(v, {27'h0, tlb_regs_pkg::VICTIM_TOP}, "victim reset");
      pipe.rd_reg(tlb_regs_pkg::SEL_PROBE_INDEX, v);
      chk(v, 32'h0, "index reset");
      pipe.rd_reg(tlb_regs_pkg::SEL_EVEN_PAGE, v);
      chk(v, 32'h0, "even reset");
      pipe.rd_reg(tlb_regs_pkg::SEL_ODD_PAGE, v);
      chk(v, 32'h0, "odd reset");
   endtask

   task automatic t_index();
      pipe.wr_reg(tlb_regs_pkg::SEL_PROBE_INDEX, 32'hffff_ffe7, 1'b1);
      pipe.rd_reg(tlb_regs_pkg::SEL_PROBE_INDEX, v);
      chk(v, 32'h0000_0007, "index write");
      pipe.wr_reg(tlb_regs_pkg::SEL_VICTIM, 32'hffff_ffff, 1'b1);
      pipe.rd_reg(tlb_regs_pkg::SEL_VICTIM, v);
      chk({v[31:5], 5'h0}, 32'h0, "victim upper bits");
      probe_hit = 1'h0;
      probe_op  = 1'h1;
      tick();
      probe_op = 1'h0;
      pipe.rd_reg(tlb_regs_pkg::SEL_PROBE_INDEX, v);
      chk(v, 32'h8000_0007, "probe miss");
      {probe_hit, probe_idx, probe_op} = {1'h1, 5'h09, 1'h1};
      tick();
      probe_op = 1'h0;
      pipe.rd_reg(tlb_regs_pkg::SEL_PROBE_INDEX, v);
      chk(v, 32'h0000_0009, "probe hit");
      chk({27'h0, rd_idx}, 32'h9, "read index");
   endtask

   // Random writes held high stream the victim value out every cycle
   task automatic t_victim();
      int         holds, decs, wraps;
      logic [4:0] p;
      logic       ok;
      {holds, decs, wraps} = '0;
      locked    = 5'h04;
      locked_wr = 1'h1;
      tick();
      locked_wr = 1'h0;
      rw_op     = 1'h1;
      tick();
      chk({27'h0, wr_idx}, 32'h1f, "victim reload");
      p = wr_idx;
      for (int i = 0; i < 120; i++) begin
         tick();
         ok = (wr_idx == p) || (p > 5'h04 && wr_idx == p - 5'h01) ||
              (p == 5'h04 && wr_idx == 5'h1f);
         chk({31'h0, ok}, 32'h1, "victim step");
         holds += (wr_idx == p);
         decs  += (wr_idx == p - 5'h01);
         wraps += (p == 5'h04 && wr_idx == 5'h1f);
         p = wr_idx;
      end
      rw_op = 1'h0;
      chk({31'h0, holds > 0 && decs > 0 && wraps > 0}, 32'h1, "victim mix");
      tick();
   endtask

   task automatic t_pages();
      pipe.wr_reg(tlb_regs_pkg::SEL_EVEN_PAGE, 32'hffff_ffff, 1'b1);
      pipe.rd_reg(tlb_regs_pkg::SEL_EVEN_PAGE, v);
      chk(v, 32'h03ff_ffff, "inhibit off");
      {ri_en, xi_en} = 2'h3;
      pipe.wr_reg(tlb_regs_pkg::SEL_ODD_PAGE, 32'hffff_fffe, 1'b1);
      pipe.rd_reg(tlb_regs_pkg::SEL_ODD_PAGE, v);
      chk(v, 32'hc3ff_fffe, "inhibit on");
      for (int g = 0; g < 2; g++) begin
         if (g == 1) begin
            pipe.wr_reg(tlb_regs_pkg::SEL_ODD_PAGE, 32'hc3ff_ffff, 1'b0);
         end
         iw_op = 1'h1;
         tick();
         iw_op = 1'h0;
         chk({31'h0, tlb_wr}, 32'h1, "write pulse");
         chk({31'h0, wr_glob}, g, "write global");
         chk({27'h0, wr_idx}, 32'h9, "write index");
         chk(wr_even, 32'h03ff_ffff, "write even");
         chk(wr_odd, 32'hc3ff_fffe | g, "write odd");
         tick();
      end
   endtask

   task automatic t_entry_read();
      {rd_even, rd_odd, rd_glob, ent_rd} = {32'h0123_4560, 32'h0000_0042, 1'h1, 1'h1};
      tick();
      ent_rd = 1'h0;
      pipe.rd_reg(tlb_regs_pkg::SEL_EVEN_PAGE, v);
      chk(v, 32'h0123_4561, "read even");
      pipe.rd_reg(tlb_regs_pkg::SEL_ODD_PAGE, v);
      chk(v, 32'h0000_0043, "read odd");
   endtask

   task automatic acc(input logic [1:0] k, input logic [31:0] pg, input logic [11:0] off,
                      input logic ei, input logic em, input logic [31:0] epa,
                      input logic [2:0] ea);
      {acc_kind, acc_page, acc_off, acc_req} = {k, pg, off, 1'h1};
      tick();
      acc_req = 1'h0;
      chk({31'h0, acc_done}, 32'h1, "access done");
      chk({31'h0, inval}, {31'h0, ei}, "invalid");
      chk({31'h0, modif}, {31'h0, em}, "modified");
      chk(pa, epa, "phys addr");
      chk({29'h0, attr}, {29'h0, ea}, "attribute");
      tick();
   endtask

   // Frame 12345 with valid, coherency 3; only the case under test is changed
   task automatic t_access();
      acc(2'h1, 32'h0048_d15a, 12'habc, 1'h0, 1'h0, 32'h1234_5abc, 3'h3);
      acc(2'h3, 32'h0048_d15a, 12'habc, 1'h0, 1'h1, 32'h1234_5abc, 3'h3);
      acc(2'h3, 32'h0048_d15e, 12'habc, 1'h0, 1'h0, 32'h1234_5abc, 3'h3);
      acc(2'h0, 32'h0048_d158, 12'h000, 1'h1, 1'h0, 32'h1234_5000, 3'h3);
      acc(2'h1, 32'h8048_d15a, 12'h000, 1'h1, 1'h0, 32'h1234_5000, 3'h3);
      acc(2'h0, 32'h4048_d15a, 12'h000, 1'h1, 1'h0, 32'h1234_5000, 3'h3);
      {ri_en, xi_en, sp_sup} = 3'h1;
      acc(2'h1, 32'h8048_d15a, 12'h000, 1'h0, 1'h0, 32'h1234_5000, 3'h3);
      acc(2'h0, 32'h4048_d15a, 12'habc, 1'h0, 1'h0, 32'h1234_5abc, 3'h3);
      sp_en = 1'h1;
      acc(2'h1, 32'h0048_d15a, 12'habc, 1'h0, 1'h0, 32'h048d_16bc, 3'h3);
      sp_en = 1'h0;
      for (int c = 0; c < 8; c++) begin
         acc(2'h1, 32'h0048_d142 | (c << 3), 12'h000, 1'h0, 1'h0, 32'h1234_5000,
             amap[c]);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk);
      #1;
      nrst = 1'h1;
      t_reset();
      t_index();
      t_victim();
      t_pages();
      t_entry_read();
      t_access();
      close_out();
   end

   // Whole run is well under a thousand cycles; this only cuts a hang short
   initial begin
      #20us;
      n_fail++;
      close_out();
   end
endmodule // tlb_index_random_entry_regs_tb_top
